// ===== src/pcsm_regs.vh
`ifndef PCSM_REGS_VH
`define PCSM_REGS_VH
// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define PCSM_ADDR_W        4
`define PCSM_A_CTRL        4'h0
`define PCSM_A_STATUS      4'h1
`define PCSM_A_GAIN0       4'h2
`define PCSM_A_GAIN1       4'h3
`define PCSM_A_VOL_MON     4'h4
`define PCSM_A_VOL_HP      4'h5
`define PCSM_A_LEVEL0      4'h6
`define PCSM_A_LEVEL1      4'h7
// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define PCSM_CTRL_STEP     3:0
`define PCSM_CTRL_CLIP     15:8
// ----------------------------------------------------------------
// Settings
// ----------------------------------------------------------------
`define PCSM_GAIN_W        7
`define PCSM_VOL_W         7
`define PCSM_GAIN_MAX      7'h41
`define PCSM_VOL_MAX       7'h7f
`define PCSM_GAIN_RST      7'h00
`define PCSM_VOL_RST       7'h00
`define PCSM_STEP_RST      4'h1
`define PCSM_CLIP_RST      8'hf8
// ----------------------------------------------------------------
// Debounce: 10 ms at 100 MHz
// ----------------------------------------------------------------
`define PCSM_DEB_CYC       20'hf4240
`define PCSM_DEB_W         20
// ----------------------------------------------------------------
// Source codes and modes
// ----------------------------------------------------------------
`define PCSM_SRC_MIC       2'h0
`define PCSM_SRC_LINE      2'h1
`define PCSM_SRC_INST      2'h2
`define PCSM_MODE_PRE      1'b0
`define PCSM_MODE_MON      1'b1
`endif

// ===== src/pcsm_debounce.v
`timescale 1ns/100ps
`include "pcsm_regs.vh"
module pcsm_debounce #(
  parameter [`PCSM_DEB_W-1:0] DEB_CYC = `PCSM_DEB_CYC
) (
  input  wire ref_clk_i,
  input  wire rst_n_i,
  input  wire raw_i,
  output reg  level_o,
  output reg  rise_o
);
  reg [`PCSM_DEB_W-1:0] cnt_r;
  reg                   sync_r;

  // ----------------------------------------------------------------
  // Level must hold steady for the whole window before it is taken
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_r  <= 1'b0;
      cnt_r   <= {`PCSM_DEB_W{1'b0}};
      level_o <= 1'b0;
      rise_o  <= 1'b0;
    end else begin
      sync_r <= raw_i;
      rise_o <= 1'b0;
      if (sync_r == level_o) begin
        cnt_r <= {`PCSM_DEB_W{1'b0}};
      end else if (cnt_r >= DEB_CYC - 1'b1) begin
        cnt_r   <= {`PCSM_DEB_W{1'b0}};
        level_o <= sync_r;
        rise_o  <= sync_r;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end
endmodule // pcsm_debounce

// ===== src/pcsm_panel.v
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/100ps
`include "pcsm_regs.vh"
// Operation
// - Preamp press in preamp mode flips selected input channel; indicators show it.
// - Input select press flips selected channel source between mic and line.
// - No plug-type sensing; mic/line changes only by input press in preamp mode.
// - Instrument plug inserted forces channel one to instrument source.
// - Channel one mic/line returns only after the instrument plug is removed.
// - Knob turn in preamp mode changes gain only: the selected channel's, or both channels' when linked.
// - Per-channel level meter output; red clip light when level reaches clip.
// - Per-channel pad toggled by its option button.
// - Monitor press alternates output selection; exactly one output indicator lit.
// - Knob turn in monitor mode changes selected output volume only.
// - Knob press in monitor mode with monitor output selected toggles monitor mute.
// - Muted and monitor selected: LED ring red instead of green.
// - Link option: adjustments on selected input apply to both channels.
// - Preamp button enters preamp mode, monitor button enters monitor mode.
// - Press of active mode button changes selection within that mode.
module pcsm_panel #(
  parameter [`PCSM_DEB_W-1:0] DEB_CYC = `PCSM_DEB_CYC
) (
  input  wire                      ref_clk_i,
  input  wire                      rst_n_i,
  input  wire                      preamp_btn_i,
  input  wire                      monitor_btn_i,
  input  wire                      input_btn_i,
  input  wire                      pad_btn_i,
  input  wire                      link_btn_i,
  input  wire                      knob_press_i,
  input  wire                      knob_up_i,
  input  wire                      knob_down_i,
  input  wire                      instrument_input_jack_i,
  input  wire [7:0]                level0_i,
  input  wire [7:0]                level1_i,
  input  wire [`PCSM_ADDR_W-1:0]   addr_i,
  input  wire [31:0]               wdata_i,
  input  wire                      wr_i,
  input  wire                      rd_i,
  output reg  [31:0]               rdata_o,
  output reg                       mode_o,
  output reg                       first_channel_indicator_o,
  output reg                       second_channel_indicator_o,
  output reg                       mic_ind_o,
  output reg                       line_ind_o,
  output reg                       instrument_input_ind_o,
  output reg                       pad_ind_o,
  output reg                       link_ind_o,
  output reg  [7:0]                meter0_o,
  output reg  [7:0]                meter1_o,
  output reg                       clip0_o,
  output reg                       clip1_o,
  output reg                       monitor_sel_ind_o,
  output reg                       headphone_sel_ind_o,
  output reg                       mute_o,
  output reg                       ring_red_o,
  output reg                       ring_green_o,
  output reg  [1:0]                src0_o,
  output reg  [1:0]                src1_o,
  output reg                       pad0_o,
  output reg                       pad1_o,
  output reg  [`PCSM_GAIN_W-1:0]   gain0_o,
  output reg  [`PCSM_GAIN_W-1:0]   gain1_o,
  output reg  [`PCSM_VOL_W-1:0]    vol_mon_o,
  output reg  [`PCSM_VOL_W-1:0]    vol_hp_o
);
  // ----------------------------------------------------------------
  // Debounced inputs
  // ----------------------------------------------------------------
  localparam NIN = 6;
  wire [NIN-1:0] raw_w;
  wire [NIN-1:0] lvl_w;
  wire [NIN-1:0] prs_w;
  assign raw_w = {instrument_input_jack_i, knob_press_i, link_btn_i,
                  pad_btn_i, input_btn_i, monitor_btn_i ^ 1'b0};
  // Preamp has its own filter: its press outranks every other control
  wire pre_prs_w;
  pcsm_debounce #(.DEB_CYC(DEB_CYC)) u_deb_pre (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .raw_i     (preamp_btn_i),
    .level_o   (),
    .rise_o    (pre_prs_w)
  );
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi = gi + 1) begin : g_deb
      pcsm_debounce #(.DEB_CYC(DEB_CYC)) u_deb (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .raw_i     (raw_w[gi]),
        .level_o   (lvl_w[gi]),
        .rise_o    (prs_w[gi])
      );
    end
  endgenerate
  wire mon_prs_w  = prs_w[0];
  wire in_prs_w   = prs_w[1];
  wire pad_prs_w  = prs_w[2];
  wire link_prs_w = prs_w[3];
  wire knob_prs_w = prs_w[4];
  // Jack is taken as a level: the override lasts while the debounced plug level stays high
  wire jack_w     = lvl_w[5];

  // ----------------------------------------------------------------
  // Panel state
  // ----------------------------------------------------------------
  localparam MODE_PRE = `PCSM_MODE_PRE;
  localparam MODE_MON = `PCSM_MODE_MON;
  reg                    mode_r;
  reg                    chan_r;
  reg                    out_r;
  reg  [1:0]             ml_r;      // Mic/line choice per channel
  reg  [1:0]             pad_r;
  reg                    link_r;
  reg                    mute_r;
  reg  [`PCSM_GAIN_W-1:0] gain_r [0:1];
  reg  [`PCSM_VOL_W-1:0]  vol_r  [0:1];
  reg  [3:0]             step_r;
  reg  [7:0]             clip_r;

  // ----------------------------------------------------------------
  // Knob step, saturating at zero and at the top of the range
  // ----------------------------------------------------------------
  function [`PCSM_GAIN_W-1:0] adj;
    input [`PCSM_GAIN_W-1:0] v;
    input                    up;
    input [`PCSM_GAIN_W-1:0] maxv;
    input [3:0]              st;
    reg   [`PCSM_GAIN_W:0]   t;
    begin
      if (up) begin
        t = {1'b0, v} + {4'h0, st};
        adj = (t > {1'b0, maxv}) ? maxv : t[`PCSM_GAIN_W-1:0];
      end else begin
        adj = (v > {3'h0, st}) ? v - {3'h0, st} : {`PCSM_GAIN_W{1'b0}};
      end
    end
  endfunction

  // Instrument plug outranks the stored mic/line choice, which survives for removal
  function [1:0] src_code;
    input jack;
    input line_sel;
    begin
      if (jack)
        src_code = `PCSM_SRC_INST;
      else if (line_sel)
        src_code = `PCSM_SRC_LINE;
      else
        src_code = `PCSM_SRC_MIC;
    end
  endfunction

  // Both detent pulses at once cancel, so a glitch never steps the value
  wire turn_w = knob_up_i ^ knob_down_i;
  wire pre_w  = (mode_r == MODE_PRE);
  integer k;

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_r <= MODE_PRE;
      chan_r <= 1'b0;
      out_r  <= 1'b0;
      ml_r   <= 2'h0;
      pad_r  <= 2'h0;
      link_r <= 1'b0;
      mute_r <= 1'b0;
      for (k = 0; k < 2; k = k + 1) begin
        gain_r[k] <= `PCSM_GAIN_RST;
        vol_r[k]  <= `PCSM_VOL_RST;
      end
    end else begin
      // Mode buttons win; a knob or option change in the same cycle is dropped
      if (pre_prs_w) begin
        mode_r <= MODE_PRE;
        if (pre_w) chan_r <= ~chan_r;
      end else if (mon_prs_w) begin
        mode_r <= MODE_MON;
        if (!pre_w) out_r <= ~out_r;
      end else if (pre_w) begin
        if (knob_prs_w) chan_r <= ~chan_r;
        // Mic/line is stored even under the instrument override
        if (in_prs_w) begin
          ml_r[chan_r] <= ~ml_r[chan_r];
          // Linked: the new value is copied so the two channels never drift apart
          if (link_r) ml_r[~chan_r] <= ~ml_r[chan_r];
        end
        if (pad_prs_w) begin
          pad_r[chan_r] <= ~pad_r[chan_r];
          if (link_r) pad_r[~chan_r] <= ~pad_r[chan_r];
        end
        if (link_prs_w) link_r <= ~link_r;
        if (turn_w) begin
          gain_r[chan_r] <= adj(gain_r[chan_r], knob_up_i, `PCSM_GAIN_MAX, step_r);
          if (link_r)
            gain_r[~chan_r] <= adj(gain_r[chan_r], knob_up_i, `PCSM_GAIN_MAX, step_r);
        end
      end else begin
        if (knob_prs_w && !out_r) mute_r <= ~mute_r;
        if (turn_w)
          vol_r[out_r] <= adj(vol_r[out_r], knob_up_i, `PCSM_VOL_MAX, step_r);
      end
    end
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      step_r  <= `PCSM_STEP_RST;
      clip_r  <= `PCSM_CLIP_RST;
      rdata_o <= 32'h0;
    end else begin
      if (wr_i && addr_i == `PCSM_A_CTRL) begin
        step_r <= wdata_i[`PCSM_CTRL_STEP];
        clip_r <= wdata_i[`PCSM_CTRL_CLIP];
      end
      // Read data live for one cycle only, so a stale word never looks fresh
      rdata_o <= 32'h0;
      if (rd_i) begin
        case (addr_i)
          `PCSM_A_CTRL:    rdata_o <= {16'h0, clip_r, 4'h0, step_r};
          `PCSM_A_STATUS:  rdata_o <= {22'h0, jack_w, mute_r,
                                       link_r, pad_r, ml_r,
                                       out_r, chan_r, mode_r};
          `PCSM_A_GAIN0:   rdata_o <= {25'h0, gain_r[0]};
          `PCSM_A_GAIN1:   rdata_o <= {25'h0, gain_r[1]};
          `PCSM_A_VOL_MON: rdata_o <= {25'h0, vol_r[0]};
          `PCSM_A_VOL_HP:  rdata_o <= {25'h0, vol_r[1]};
          `PCSM_A_LEVEL0:  rdata_o <= {24'h0, level0_i};
          `PCSM_A_LEVEL1:  rdata_o <= {24'h0, level1_i};
          default:         rdata_o <= 32'h0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all registered
  // ----------------------------------------------------------------
  wire [1:0] s0_w = src_code(jack_w, ml_r[0]);
  // Second channel has no instrument jack, so it never takes the override
  wire [1:0] s1_w = src_code(1'b0, ml_r[1]);
  wire [1:0] ss_w = chan_r ? s1_w : s0_w;
  // Ring follows mute only while the monitor output is picked; headphones stay green
  wire       red_w = mute_r && !out_r;

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_o <= 1'b0;
      first_channel_indicator_o <= 1'b0;
      second_channel_indicator_o <= 1'b0;
      mic_ind_o <= 1'b0;
      line_ind_o <= 1'b0;
      instrument_input_ind_o <= 1'b0;
      pad_ind_o <= 1'b0;
      link_ind_o <= 1'b0;
      meter0_o <= 8'h0;
      meter1_o <= 8'h0;
      clip0_o <= 1'b0;
      clip1_o <= 1'b0;
      monitor_sel_ind_o <= 1'b0;
      headphone_sel_ind_o <= 1'b0;
      mute_o <= 1'b0;
      ring_red_o <= 1'b0;
      ring_green_o <= 1'b0;
      src0_o <= 2'h0;
      src1_o <= 2'h0;
      pad0_o <= 1'b0;
      pad1_o <= 1'b0;
      gain0_o <= `PCSM_GAIN_RST;
      gain1_o <= `PCSM_GAIN_RST;
      vol_mon_o <= `PCSM_VOL_RST;
      vol_hp_o <= `PCSM_VOL_RST;
    end else begin
      mode_o <= mode_r;
      first_channel_indicator_o  <= ~chan_r;
      second_channel_indicator_o <= chan_r;
      mic_ind_o  <= (ss_w == `PCSM_SRC_MIC);
      line_ind_o <= (ss_w == `PCSM_SRC_LINE);
      instrument_input_ind_o <= (ss_w == `PCSM_SRC_INST);
      pad_ind_o  <= pad_r[chan_r];
      link_ind_o <= link_r;
      meter0_o <= level0_i;
      meter1_o <= level1_i;
      clip0_o  <= (level0_i >= clip_r);
      clip1_o  <= (level1_i >= clip_r);
      monitor_sel_ind_o   <= ~out_r;
      headphone_sel_ind_o <= out_r;
      mute_o       <= mute_r;
      ring_red_o   <= red_w;
      ring_green_o <= ~red_w;
      src0_o <= s0_w;
      src1_o <= s1_w;
      pad0_o <= pad_r[0];
      pad1_o <= pad_r[1];
      gain0_o <= gain_r[0];
      gain1_o <= gain_r[1];
      vol_mon_o <= vol_r[0];
      vol_hp_o  <= vol_r[1];
    end
  end
endmodule // pcsm_panel

// ===== sim/pcsm_panel_assertions.sv
`timescale 1ns/100ps
`include "pcsm_regs.vh"
// ----------------------------------------------------------------
// Port checks of the panel state
// ----------------------------------------------------------------
module pcsm_panel_assertions #(
  parameter [`PCSM_DEB_W-1:0] DEB_CYC = `PCSM_DEB_CYC
) (
  input wire                     ref_clk_i,
  input wire                     rst_n_i,
  input wire                     instrument_input_jack_i,
  input wire                     mode_o,
  input wire                     first_channel_indicator_o,
  input wire                     second_channel_indicator_o,
  input wire                     monitor_sel_ind_o,
  input wire                     headphone_sel_ind_o,
  input wire                     mute_o,
  input wire                     ring_red_o,
  input wire                     ring_green_o,
  input wire [1:0]               src0_o,
  input wire [`PCSM_GAIN_W-1:0]  gain0_o,
  input wire [`PCSM_VOL_W-1:0]   vol_mon_o
);
  // Steady jack cycles until the source output follows: sync, debounce, output flop, plus one spare cycle
  localparam int DEB_LAT = DEB_CYC + 3;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // The debounce window is far too long to unroll, so steady runs are counted here
  logic [`PCSM_DEB_W:0] jack_hi_r;
  logic [`PCSM_DEB_W:0] jack_lo_r;
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      jack_hi_r <= '0;
      jack_lo_r <= '0;
    end else begin
      if (!instrument_input_jack_i) jack_hi_r <= '0;
      else if (jack_hi_r < DEB_LAT) jack_hi_r <= jack_hi_r + 1'b1;
      if (instrument_input_jack_i) jack_lo_r <= '0;
      else if (jack_lo_r < DEB_LAT) jack_lo_r <= jack_lo_r + 1'b1;
    end
  end
  sequence s_jack_held;
    jack_hi_r >= DEB_LAT;
  endsequence
  sequence s_jack_gone;
    jack_lo_r >= DEB_LAT;
  endsequence
  a_chan_one_hot: assert property (
    $past(rst_n_i) |-> first_channel_indicator_o ^ second_channel_indicator_o)
    else $error("channel indicators not one-hot");
  a_out_one_hot: assert property (
    $past(rst_n_i) |-> monitor_sel_ind_o ^ headphone_sel_ind_o)
    else $error("output indicators not one-hot");
  a_ring_red_mute: assert property (
    mute_o && monitor_sel_ind_o && $past(mute_o && monitor_sel_ind_o) |-> ring_red_o && !ring_green_o)
    else $error("ring not red while monitor muted");
  a_jack_forces_inst: assert property (
    s_jack_held |-> src0_o == `PCSM_SRC_INST)
    else $error("plug did not force instrument source");
  a_jack_gone_free: assert property (
    s_jack_gone |-> src0_o != `PCSM_SRC_INST)
    else $error("instrument source kept without plug");
  a_gain_preamp_only: assert property (
    $changed(gain0_o) |-> $past(mode_o) == `PCSM_MODE_PRE)
    else $error("gain changed outside preamp mode");
  a_gain_limit: assert property (
    gain0_o <= `PCSM_GAIN_MAX)
    else $error("gain above maximum");
  a_vol_mon_sel: assert property (
    $changed(vol_mon_o) |-> $past(mode_o) == `PCSM_MODE_MON && $past(monitor_sel_ind_o))
    else $error("monitor volume changed while not selected");
  a_mute_mon_sel: assert property (
    $changed(mute_o) |-> monitor_sel_ind_o && $past(monitor_sel_ind_o))
    else $error("mute changed without monitor selected");
endmodule // pcsm_panel_assertions

bind pcsm_panel pcsm_panel_assertions #(.DEB_CYC(DEB_CYC)) u_chk (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .instrument_input_jack_i(instrument_input_jack_i),
  .mode_o(mode_o), .first_channel_indicator_o(first_channel_indicator_o),
  .second_channel_indicator_o(second_channel_indicator_o), .monitor_sel_ind_o(monitor_sel_ind_o),
  .headphone_sel_ind_o(headphone_sel_ind_o), .mute_o(mute_o), .ring_red_o(ring_red_o),
  .ring_green_o(ring_green_o), .src0_o(src0_o), .gain0_o(gain0_o), .vol_mon_o(vol_mon_o));

// ===== sim/pcsm_panel_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Front panel: buttons, knob and instrument jack
// ----------------------------------------------------------------
module pcsm_panel_model #(
  parameter int HOLD = 10
) (
  input  wire  ref_clk_i,
  output logic preamp_btn_o,
  output logic monitor_btn_o,
  output logic input_btn_o,
  output logic pad_btn_o,
  output logic link_btn_o,
  output logic knob_press_o,
  output logic knob_up_o,
  output logic knob_down_o,
  output logic instrument_input_jack_o
);
  logic [5:0] btn_r = 6'h00;
  assign {knob_press_o, link_btn_o, pad_btn_o, input_btn_o, monitor_btn_o, preamp_btn_o} = btn_r;
  initial begin
    knob_up_o = 1'b0;
    knob_down_o = 1'b0;
    instrument_input_jack_o = 1'b0;
  end
  // A short len gives contact bounce that must not count as a press
  task automatic press(input int idx, input int len);
    @(posedge ref_clk_i);
    btn_r[idx] <= 1'b1;
    repeat (len) @(posedge ref_clk_i);
    btn_r[idx] <= 1'b0;
    repeat (HOLD) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic turn(input logic up, input int n);
    repeat (n) begin
      @(posedge ref_clk_i);
      knob_up_o <= up;
      knob_down_o <= !up;
      @(posedge ref_clk_i);
      knob_up_o <= 1'b0;
      knob_down_o <= 1'b0;
    end
    repeat (4) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic plug(input logic v);
    @(posedge ref_clk_i);
    instrument_input_jack_o <= v;
    repeat (HOLD + 4) @(posedge ref_clk_i);
    #1;
  endtask
endmodule // pcsm_panel_model

// ===== sim/pcsm_panel_tb_top.sv
`timescale 1ns/100ps
`include "pcsm_regs.vh"
module pcsm_panel_tb_top;
  localparam [`PCSM_DEB_W-1:0] DEB = 20'h00004;
  logic       ref_clk_i = 1'b0;
  logic       rst_n_i   = 1'b0;
  logic [7:0] level0_i  = 8'h00;
  logic [7:0] level1_i  = 8'h00;
  logic [3:0] addr_i    = 4'h0;
  logic [31:0] wdata_i  = 32'h0;
  logic       wr_i      = 1'b0;
  logic       rd_i      = 1'b0;
  int         err_total = 0;
  int         n_compared = 0;
  wire        pre_b, mon_b, inp_b, pad_b, lnk_b, kp_b, k_up, k_dn, jack;
  always #5 ref_clk_i = !ref_clk_i;
  pcsm_panel_model #(.HOLD(10)) PANEL (.ref_clk_i(ref_clk_i), .preamp_btn_o(pre_b),
    .monitor_btn_o(mon_b), .input_btn_o(inp_b), .pad_btn_o(pad_b), .link_btn_o(lnk_b),
    .knob_press_o(kp_b), .knob_up_o(k_up), .knob_down_o(k_dn), .instrument_input_jack_o(jack));
  pcsm_panel #(.DEB_CYC(DEB)) DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .preamp_btn_i(pre_b), .monitor_btn_i(mon_b), .input_btn_i(inp_b), .pad_btn_i(pad_b),
    .link_btn_i(lnk_b), .knob_press_i(kp_b), .knob_up_i(k_up), .knob_down_i(k_dn),
    .instrument_input_jack_i(jack), .level0_i(level0_i), .level1_i(level1_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(), .mode_o(),
    .first_channel_indicator_o(), .second_channel_indicator_o(), .mic_ind_o(), .line_ind_o(),
    .instrument_input_ind_o(), .pad_ind_o(), .link_ind_o(), .meter0_o(), .meter1_o(),
    .clip0_o(), .clip1_o(), .monitor_sel_ind_o(), .headphone_sel_ind_o(), .mute_o(),
    .ring_red_o(), .ring_green_o(), .src0_o(), .src1_o(), .pad0_o(), .pad1_o(), .gain0_o(),
    .gain1_o(), .vol_mon_o(), .vol_hp_o());
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input string nm, input logic [3:0] a, input logic [31:0] e);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1;
    chk(nm, e, DUT.rdata_o);
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk("first_ind", 1, DUT.first_channel_indicator_o);
    chk("mic_ind", 1, DUT.mic_ind_o);
    chk("mon_sel", 1, DUT.monitor_sel_ind_o);
    chk("ring_green", 1, DUT.ring_green_o);
    rd_chk("ctrl", `PCSM_A_CTRL, 32'h0000f801);
    rd_chk("status", `PCSM_A_STATUS, 32'h00000000);
    rd_chk("unmapped", 4'h8, 32'h00000000);
    wr(4'h9, 32'hffffffff);
    wr(`PCSM_A_CTRL, 32'h0000f802);
    rd_chk("ctrl", `PCSM_A_CTRL, 32'h0000f802);
    $display("test reset done");
    PANEL.turn(1'b1, 3);
    chk("gain0", 6, DUT.gain0_o);
    PANEL.turn(1'b0, 4);
    chk("gain0", 0, DUT.gain0_o);
    wr(`PCSM_A_CTRL, 32'h0000f80f);
    PANEL.turn(1'b1, 5);
    chk("gain0", `PCSM_GAIN_MAX, DUT.gain0_o);
    chk("gain1", 0, DUT.gain1_o);
    wr(`PCSM_A_CTRL, 32'h0000f802);
    $display("test gain done");
    PANEL.press(0, 10);
    chk("second_ind", 1, DUT.second_channel_indicator_o);
    PANEL.turn(1'b1, 1);
    chk("gain1", 2, DUT.gain1_o);
    chk("gain0", `PCSM_GAIN_MAX, DUT.gain0_o);
    PANEL.press(2, 10);
    chk("src1", `PCSM_SRC_LINE, DUT.src1_o);
    chk("line_ind", 1, DUT.line_ind_o);
    chk("src0", `PCSM_SRC_MIC, DUT.src0_o);
    PANEL.press(2, 2);
    chk("src1", `PCSM_SRC_LINE, DUT.src1_o);
    PANEL.press(3, 10);
    chk("pad1", 1, DUT.pad1_o);
    chk("pad_ind", 1, DUT.pad_ind_o);
    chk("pad0", 0, DUT.pad0_o);
    PANEL.press(4, 10);
    chk("link_ind", 1, DUT.link_ind_o);
    PANEL.turn(1'b1, 1);
    chk("gain1", 4, DUT.gain1_o);
    chk("gain0", 4, DUT.gain0_o);
    rd_chk("status", `PCSM_A_STATUS, 32'h000000d2);
    rd_chk("gain0_reg", `PCSM_A_GAIN0, 32'h00000004);
    $display("test channel done");
    PANEL.press(0, 10);
    chk("first_ind", 1, DUT.first_channel_indicator_o);
    PANEL.plug(1'b1);
    chk("src0", `PCSM_SRC_INST, DUT.src0_o);
    chk("inst_ind", 1, DUT.instrument_input_ind_o);
    PANEL.plug(1'b0);
    chk("src0", `PCSM_SRC_MIC, DUT.src0_o);
    chk("mic_ind", 1, DUT.mic_ind_o);
    chk("src1", `PCSM_SRC_LINE, DUT.src1_o);
    $display("test jack done");
    PANEL.press(1, 10);
    chk("mode", `PCSM_MODE_MON, DUT.mode_o);
    chk("mon_sel", 1, DUT.monitor_sel_ind_o);
    PANEL.turn(1'b1, 1);
    chk("vol_mon", 2, DUT.vol_mon_o);
    chk("gain1", 4, DUT.gain1_o);
    PANEL.press(5, 10);
    chk("mute", 1, DUT.mute_o);
    chk("ring_red", 1, DUT.ring_red_o);
    PANEL.press(1, 10);
    chk("hp_sel", 1, DUT.headphone_sel_ind_o);
    PANEL.press(5, 10);
    chk("mute", 1, DUT.mute_o);
    PANEL.turn(1'b1, 2);
    chk("vol_hp", 4, DUT.vol_hp_o);
    chk("vol_mon", 2, DUT.vol_mon_o);
    rd_chk("vol_hp_reg", `PCSM_A_VOL_HP, 32'h00000004);
    $display("test output done");
    @(posedge ref_clk_i);
    level0_i <= 8'hf8;
    level1_i <= 8'hf7;
    repeat (3) @(posedge ref_clk_i);
    #1;
    chk("clip0", 1, DUT.clip0_o);
    chk("clip1", 0, DUT.clip1_o);
    chk("meter0", 8'hf8, DUT.meter0_o);
    chk("meter1", 8'hf7, DUT.meter1_o);
    rd_chk("level0", `PCSM_A_LEVEL0, 32'h000000f8);
    rd_chk("level1", `PCSM_A_LEVEL1, 32'h000000f7);
    $display("test meter done");
    conclude();
  end
  // Whole run needs well under 2000 cycles
  initial begin
    #100000;
    err_total++;
    conclude();
  end
endmodule // pcsm_panel_tb_top
